// [hw/status_regs.sv]
// Upper status register bank reached over the two-wire management link.
// Assumes SCL/SDA arrive raw from pins; SDA is open drain, pulled up outside.
`timescale 1ns/1ps
`include "status_regs_map.svh"
module status_regs (
    input  wire logic       mclk,           // 40 MHz system clock
    input  wire logic       resetn,         // Synchronous reset, active low
    input  wire logic [7:0] enable_pins_n,  // Enable pins 12..5, active low
    input  wire logic [6:0] link_addr,      // Seven-bit link address
    input  wire logic       scl_in,         // Link clock pin level
    input  wire logic       sda_in,         // Link data pin level
    output logic            sda_out,        // Link data drive value (always 0)
    output logic            sda_oe_n,       // Drive enable, low pulls SDA low
    output logic [4:0]      read_count      // Current byte-count field
);
    parameter logic [3:0] REVISION = 4'h1; // Arbitrary value
    parameter logic [3:0] MAKER    = 4'h2; // Arbitrary value
    parameter logic [7:0] PART_ID  = 8'h5a; // Arbitrary value

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [7:0] pins_s; // Filtered enable pin levels
    logic [1:0] link_s; // Filtered SCL, SDA
    pin_sync #(.W(8)) u_pins (
        .mclk   (mclk),
        .resetn (resetn),
        .din    (enable_pins_n),
        .dout   (pins_s)
    );
    pin_sync #(.W(2)) u_link (
        .mclk   (mclk),
        .resetn (resetn),
        .din    ({scl_in, sda_in}),
        .dout   (link_s)
    );
    logic [6:0] addr_s; // Filtered link address straps
    pin_sync #(.W(7)) u_addr (
        .mclk   (mclk),
        .resetn (resetn),
        .din    (link_addr),
        .dout   (addr_s)
    );

    // ----------------------------------------
    // Link edge and condition detection
    // ----------------------------------------
    // Reset to the idle high level so no false edge follows reset
    // Start and stop need SCL high in both samples, so data moves never match
    logic scl_q;  // Previous SCL
    logic sda_q;  // Previous SDA
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= link_s[1];
            sda_q <= link_s[0];
        end
    end
    wire scl_rise = link_s[1] & ~scl_q;             // Sample point
    wire scl_fall = ~link_s[1] & scl_q;             // Drive point
    wire start_c  = link_s[1] & scl_q & sda_q & ~link_s[0];
    wire stop_c   = link_s[1] & scl_q & ~sda_q & link_s[0];

    // ----------------------------------------
    // Register read decode
    // ----------------------------------------
    logic [4:0] count_q; // Byte-count field
    function automatic logic [7:0] reg_read(input logic [7:0] idx);
        unique case (idx)
            `IDX_PIN_READBACK: reg_read = pins_s;                    // [RULE1]
            `IDX_REV_MAKER:    reg_read = {REVISION, MAKER};         // [RULE3]
            `IDX_PART_IDENT:   reg_read = PART_ID;                   // [RULE4]
            `IDX_READ_LENGTH:  reg_read = {3'b000, count_q};         // [RULE5]
            default:           reg_read = `SPARE_VALUE;              // [RULE2]
        endcase
    endfunction : reg_read

    // ----------------------------------------
    // Link engine
    // ----------------------------------------
    status_regs_pkg::link_state_t state_q;
    logic [7:0] shift_q;    // Shift register
    logic [3:0] bit_q;      // Bits remaining in current byte
    logic       rnw_q;      // Current transfer is a read
    logic       first_q;    // Next write byte is the index
    logic       cnt_sent_q; // Count byte already sent in this read
    logic [7:0] index_q;    // Register index pointer
    logic       ack_drv_q;  // Drive acknowledge during this slot

    // Bytes 0..2 belong to another bank; this bank still answers them as zero.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_q    <= status_regs_pkg::ST_IDLE;
            shift_q    <= 8'h00;
            bit_q      <= 4'h0;
            rnw_q      <= 1'b0;
            first_q    <= 1'b0;
            cnt_sent_q <= 1'b0;
            index_q    <= 8'h00;
            ack_drv_q  <= 1'b0;
        end else if (stop_c) begin
            state_q <= status_regs_pkg::ST_IDLE;
        end else if (start_c) begin
            // Repeated start keeps the index written earlier
            state_q <= status_regs_pkg::ST_ADDR;                     // [RULE7]
            bit_q   <= `BITS_PER_BYTE;
        end else begin
            unique case (state_q)
                status_regs_pkg::ST_IDLE, status_regs_pkg::ST_SKIP: begin
                    // Hold until a start; a foreign transfer is ignored
                end
                status_regs_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], link_s[0]};
                        bit_q   <= bit_q - 4'd1;
                    end
                    if (scl_fall && bit_q == 4'd0) begin
                        if (shift_q[7:1] == addr_s) begin
                            rnw_q      <= shift_q[0];
                            first_q    <= ~shift_q[0];
                            cnt_sent_q <= 1'b0;
                            ack_drv_q  <= 1'b1;
                            state_q    <= status_regs_pkg::ST_AACK;
                        end else begin
                            state_q <= status_regs_pkg::ST_SKIP;
                        end
                    end
                end
                status_regs_pkg::ST_AACK: begin
                    // Acknowledge bit ends on the next falling edge
                    if (scl_fall) begin
                        ack_drv_q <= 1'b0;
                        bit_q     <= `BITS_PER_BYTE;
                        if (rnw_q) begin
                            // Count byte first, then register bytes [RULE8]
                            shift_q    <= cnt_sent_q ? reg_read(index_q)
                                                     : {3'b000, count_q};
                            state_q    <= status_regs_pkg::ST_RBYTE;
                        end else begin
                            state_q <= status_regs_pkg::ST_WBYTE;
                        end
                    end
                end
                status_regs_pkg::ST_WBYTE: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], link_s[0]};
                        bit_q   <= bit_q - 4'd1;
                    end
                    if (scl_fall && bit_q == 4'd0) begin
                        if (first_q) begin
                            index_q <= shift_q;                      // [RULE7]
                            first_q <= 1'b0;
                        end else begin
                            // The count field takes its write elsewhere
                            index_q <= index_q + 8'h01;
                        end
                        ack_drv_q <= 1'b1;
                        state_q   <= status_regs_pkg::ST_AACK;
                    end
                end
                status_regs_pkg::ST_RBYTE: begin
                    if (scl_fall) begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        bit_q   <= bit_q - 4'd1;
                        if (bit_q == 4'd1) begin
                            state_q <= status_regs_pkg::ST_RACK;
                        end
                    end
                end
                status_regs_pkg::ST_RACK: begin
                    // Host NACK ends the read; ACK continues    [RULE8]
                    if (scl_rise) begin
                        if (link_s[0]) begin
                            state_q <= status_regs_pkg::ST_SKIP;
                        end else begin
                            if (cnt_sent_q) begin
                                index_q <= index_q + 8'd1;
                            end
                            cnt_sent_q <= 1'b1;
                            state_q    <= status_regs_pkg::ST_AACK;
                        end
                    end
                end
                default: state_q <= status_regs_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Byte-count field
    // ----------------------------------------
    // Data byte complete at index seven; every other index takes no write
    // Takes effect on the falling edge that ends the byte's eighth bit
    wire count_wr_c = (state_q == status_regs_pkg::ST_WBYTE) && scl_fall &&
                      (bit_q == 4'h0) && !first_q && !start_c && !stop_c &&
                      (index_q == `IDX_READ_LENGTH);                  // [RULE9]
    // Reserved bits seven to five are dropped on purpose
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            count_q <= `COUNT_RESET;                                 // [RULE6]
        end else if (count_wr_c) begin
            count_q <= shift_q[`COUNT_MSB:0];                        // [RULE5]
        end
    end

    // ----------------------------------------
    // Pin drivers, registered
    // ----------------------------------------
    // SDA low when acknowledging or sending a zero data bit
    // Registered so the pin sees no decode glitch; one cycle is far inside SCL low
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sda_out    <= 1'b0;
            sda_oe_n   <= 1'b1;
            read_count <= `COUNT_RESET;
        end else begin
            sda_out    <= 1'b0;
            sda_oe_n   <= ~(ack_drv_q ||
                           (state_q == status_regs_pkg::ST_RBYTE && !shift_q[7]));
            read_count <= count_q;
        end
    end
endmodule : status_regs

// [hw/status_regs_map.svh]
// Constants for the upper status register bank of the clock buffer.
// Assumes byte-wide register access over the serial management link.
// Operation
// RULE1: Byte three reads live enable pin levels
// RULE2: Bytes four and eight reserved, read zero
// RULE3: Byte five holds revision and maker nibbles
// RULE4: Byte six returns fixed part identifier
// RULE5: Byte seven holds writable five-bit count
// RULE6: Count resets to eight, nine bytes read
// RULE7: Host writes index then repeated-start read
// RULE8: Block read sends count then bytes
// RULE9: Writes to read-only bits change nothing
`ifndef STATUS_REGS_MAP_SVH
`define STATUS_REGS_MAP_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_PIN_READBACK   8'h03
`define IDX_SPARE_A        8'h04
`define IDX_REV_MAKER      8'h05
`define IDX_PART_IDENT     8'h06
`define IDX_READ_LENGTH    8'h07
`define IDX_SPARE_B        8'h08

// ----------------------------------------
// Field layouts and reset values
// ----------------------------------------
`define COUNT_MSB          4
`define COUNT_RESET        5'h08
`define BITS_PER_BYTE      4'h8
`define REV_LSB            4
`define SPARE_VALUE        8'h00
`define LINK_ADDR_DEFAULT  7'h6c

`endif

// [hw/status_regs_pkg.sv]
// Types shared by the status register bank.
// Assumes the constant header is compiled alongside.
package status_regs_pkg;
    // ----------------------------------------
    // Link transfer phases
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000, // Waiting for a start
        ST_ADDR  = 3'b001, // Shifting in the address byte
        ST_AACK  = 3'b010, // Acknowledging a byte
        ST_WBYTE = 3'b011, // Receiving a data byte
        ST_RBYTE = 3'b100, // Sending a data byte
        ST_RACK  = 3'b101, // Sampling host acknowledge
        ST_SKIP  = 3'b110  // Not addressed or read ended by host NACK, wait for stop or start
    } link_state_t;
endpackage : status_regs_pkg

// [hw/pin_sync.sv]
// Three-stage synchroniser with agreement filter for external levels.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/1ps
`include "status_regs_map.svh"
module pin_sync #(
    parameter int W = 8
) (
    input  wire logic         mclk,   // System clock
    input  wire logic         resetn, // Synchronous reset, active low
    input  wire logic [W-1:0] din,    // Asynchronous input levels
    output logic      [W-1:0] dout    // Filtered, synchronised levels
);
    logic [W-1:0] s1_q; // First stage, read only by s2
    logic [W-1:0] s2_q; // Second stage
    logic [W-1:0] s3_q; // Third stage

    // ----------------------------------------
    // Shift chain and agreement filter
    // ----------------------------------------
    // A bit changes only once stages two and three agree
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            dout <= '1;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : pin_sync

// [test/status_regs_asserts.sv]
// Checker for the status register bank: link drive timing and count field.
// Assumes a bind onto status_regs; one clock domain, reset active low.
`timescale 1ns/1ps
module status_regs_asserts (
    input wire logic       mclk,          // System clock
    input wire logic       resetn,        // Reset, active low
    input wire logic [7:0] enable_pins_n, // Enable pins
    input wire logic [6:0] link_addr,     // Link address
    input wire logic       scl_in,        // Link clock
    input wire logic       sda_in,        // Link data
    input wire logic       sda_out,       // Drive value
    input wire logic       sda_oe_n,      // Drive enable, active low
    input wire logic [4:0] read_count     // Count field
);
    logic [5:0] scl_age_q;  // Cycles since SCL moved, saturating
    logic       scl_prev_q; // SCL one cycle back
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // Phase age: lets checks speak of long SCL phases
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        scl_prev_q <= scl_in;
    end
    always_ff @(posedge mclk) begin
        if (!resetn || scl_in != scl_prev_q) begin
            scl_age_q <= 6'h00;
        end else if (scl_age_q != 6'h3f) begin
            scl_age_q <= scl_age_q + 6'h01;
        end
    end
    a_reset_state: assert property (
        $rose(resetn) |-> read_count == 5'h08 && sda_oe_n) else $error("bad state after reset");
    a_drive_zero: assert property (
        !sda_oe_n |-> sda_out == 1'b0) else $error("data drive is not low");
    a_drive_scl_low: assert property (
        $changed(sda_oe_n) |-> !scl_in) else $error("data drive moved while SCL high");
    a_drive_stands: assert property (
        $fell(sda_oe_n) |-> !sda_oe_n [*8]) else $error("data drive too short");
    a_drive_ends: assert property (
        $fell(sda_oe_n) |-> ##[8:250] $rose(sda_oe_n)) else $error("data drive never ends");
    a_idle_release: assert property (
        scl_in && scl_age_q > 6'd20 |-> sda_oe_n) else $error("drive during long SCL high");
    a_count_on_edge: assert property (
        $changed(read_count) |-> scl_age_q < 6'd9) else $error("count moved away from SCL edge");
    a_count_bits: assert property (
        $changed(read_count) |-> $past(scl_age_q) < 6'd8) else $error("count moved late");
    // Covers: a drive, a count write, a reset release
    cover property ($fell(sda_oe_n));
    cover property ($changed(read_count));
    cover property ($rose(resetn));
endmodule : status_regs_asserts

// [test/link_host.sv]
// Host model for the management link: drives SCL, pulls SDA low.
// Assumes the bench resolves the open-drain SDA wire with a pull-up.
`timescale 1ns/1ps
module link_host (
    input  wire logic mclk,   // System clock
    input  wire logic sda,    // Resolved data wire
    output logic      scl,    // Link clock, high when idle
    output logic      sda_low // High pulls SDA low
);
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
    endtask : hold
    // Start (rise=0) or stop (rise=1); phases kept above 8 clocks
    task automatic edge_x(input logic rise);
        sda_low <= rise;
        hold(10);
        scl <= 1'b1;
        hold(12);
        sda_low <= !rise;
        hold(12);
        if (!rise) begin
            scl <= 1'b0;
            hold(4);
        end
    endtask : edge_x
    // Data moves only with SCL low, so it can never look like a start
    task automatic bit_x(input logic b, output logic s);
        sda_low <= !b;
        hold(10);
        scl <= 1'b1;
        hold(12);
        s = sda;
        scl <= 1'b0;
        hold(4);
    endtask : bit_x
    task automatic byte_x(input logic [7:0] d, input logic b9,
                          output logic [7:0] q, output logic s9);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(b9, s9);
    endtask : byte_x
    // Indexed transfer; ok is low if any device acknowledge is missing
    task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] idx,
                        input int n, inout logic [7:0] d [0:7], output logic ok);
        logic       s;
        logic [7:0] q;
        edge_x(1'b0);
        byte_x({a, 1'b0}, 1'b1, q, s);
        ok = !s;
        byte_x(idx, 1'b1, q, s);
        ok &= !s;
        if (rd) begin
            edge_x(1'b0);
            byte_x({a, 1'b1}, 1'b1, q, s);
            ok &= !s;
        end
        for (int i = 0; i < n; i++) begin
            byte_x(rd ? 8'hff : d[i], rd ? (i == n - 1) : 1'b1, q, s);
            if (rd) d[i] = q;
            else ok &= !s;
        end
        edge_x(1'b1);
    endtask : xfer
endmodule : link_host

// [test/testbench.sv]
// Self-checking bench for the status register bank over the link.
// Assumes design, host model and checker are compiled before it.
`timescale 1ns/1ps
module testbench;
    logic       mclk = 1'b0;           // 40 MHz clock
    logic       resetn = 1'b0;         // Reset, active low
    logic [7:0] enable_pins_n = 8'ha5; // Enable pin levels
    logic [6:0] link_addr = 7'h6c;     // Device address
    logic       scl, sda_low, sda_out, sda_oe_n, ok;
    logic [4:0] read_count;
    logic [7:0] buf_q [0:7];
    int         n_mismatch = 0, num_checks = 0, cycles = 0;
    // Open-drain wire with pull-up
    wire sda = (sda_oe_n ? 1'b1 : sda_out) & !sda_low;
    always #12.5 mclk = ~mclk;
    status_regs status_regs_i (.mclk(mclk), .resetn(resetn), .enable_pins_n(enable_pins_n),
        .link_addr(link_addr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .read_count(read_count));
    link_host link_host_i (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    // Timeout: a hang counts as a mismatch
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            final_report;
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Block read from byte 3: count first, then bytes 3 to 8
    task automatic read_all(input logic [7:0] e [0:7]);
        link_host_i.xfer(link_addr, 1'b1, 8'h03, 7, buf_q, ok);
        chk("read ack", 8'h01, {7'h00, ok});
        for (int i = 0; i < 7; i++) chk("read byte", e[i], buf_q[i]);
    endtask : read_all
    task automatic t_defaults;
        chk("count", 8'h08, {3'h0, read_count});
        read_all('{8'h08, 8'ha5, 8'h00, 8'h12, 8'h5a, 8'h08, 8'h00, 8'h00});
        $display("Test defaults done");
    endtask : t_defaults
    // Write every byte 3..8; only the count field may take effect
    task automatic t_write_all;
        buf_q = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hf3, 8'hff, 8'h00, 8'h00};
        link_host_i.xfer(link_addr, 1'b0, 8'h03, 6, buf_q, ok);
        chk("write ack", 8'h01, {7'h00, ok});
        chk("count", 8'h13, {3'h0, read_count});
        @(posedge mclk) enable_pins_n <= 8'h3c;
        read_all('{8'h13, 8'h3c, 8'h00, 8'h12, 8'h5a, 8'h13, 8'h00, 8'h00});
        $display("Test write_all done");
    endtask : t_write_all
    // Foreign address: no acknowledge, count untouched
    task automatic t_bad_addr;
        buf_q[0] = 8'h01;
        link_host_i.xfer(link_addr ^ 7'h01, 1'b0, 8'h07, 1, buf_q, ok);
        chk("foreign ack", 8'h00, {7'h00, ok});
        chk("count", 8'h13, {3'h0, read_count});
        $display("Test bad_addr done");
    endtask : t_bad_addr
    // Second reset mid-run restores the count
    task automatic t_rereset;
        @(posedge mclk) resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        repeat (8) @(posedge mclk);
        read_all('{8'h08, 8'h3c, 8'h00, 8'h12, 8'h5a, 8'h08, 8'h00, 8'h00});
        $display("Test rereset done");
    endtask : t_rereset
    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        repeat (8) @(posedge mclk);
        t_defaults;
        t_write_all;
        t_bad_addr;
        t_rereset;
        final_report;
    end
endmodule : testbench
bind status_regs status_regs_asserts status_regs_asserts_i (.mclk(mclk), .resetn(resetn),
    .enable_pins_n(enable_pins_n), .link_addr(link_addr), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .read_count(read_count));
